// file: design/ebcs_sequencer.sv
// external bus cycle sequencer: runs one bus cycle per accepted request
// through setup, command delay, write setup, access and hold phases.
// assumes requests and timing come from logic on core_clk_i; only the
// read data pins come from outside and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module ebcs_sequencer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // request side
  input wire logic req_i,
  output logic req_ready_o,
  input wire logic req_we_i,
  input wire logic req_byte_hi_i,
  input wire logic [ebcs_pkg::WIN_W-1:0] req_window_i,
  input wire logic [ebcs_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [ebcs_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [ebcs_pkg::CFG_W-1:0] chip_select_timing_cfg_i,
  // answer side
  output logic rdata_valid_o,
  output logic [ebcs_pkg::DATA_W-1:0] rdata_o,
  output logic cycle_done_o,
  // bus pins
  output logic bus_reference_clock_out_o,
  output logic [ebcs_pkg::ADDR_W-1:0] addr_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic upper_byte_select_n_o,
  input wire logic [ebcs_pkg::DATA_W-1:0] data_i,
  output logic [ebcs_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o
);

  // ----------------------------------------------------------------
  // latched request
  // ----------------------------------------------------------------
  logic we; // cycle is a write
  logic byte_hi; // upper byte selected
  logic [ebcs_pkg::ADDR_W-1:0] addr; // cycle address
  logic [ebcs_pkg::DATA_W-1:0] wdata; // write data
  logic [ebcs_pkg::CFG_W-1:0] cfg; // timing of this cycle
  logic [ebcs_pkg::WIN_W-1:0] prev_win; // window of last cycle
  logic win_seen; // a cycle has run since reset
  logic win_chg; // this cycle changed window
  ebcs_pkg::ebcs_phase_t st;
  ebcs_pkg::ebcs_phase_t next_st;

  wire take = req_i & req_ready_o;
  assign req_ready_o = (st == ebcs_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // phase lengths
  // ----------------------------------------------------------------
  wire mux = cfg[ebcs_pkg::CFG_MUX_POS];
  function automatic logic [5:0] setup_len(
      input logic [ebcs_pkg::CFG_W-1:0] c, input logic chg);
    setup_len = (c[ebcs_pkg::CFG_AB_POS] ? 6'h02 : 6'h01) +
                (chg ? {4'h0, c[ebcs_pkg::CFG_ABX_POS +: 2]} : 6'h00);
  endfunction
  wire take_chg = !win_seen || (req_window_i != prev_win);
  wire [5:0] len_ab = setup_len(cfg, win_chg);
  wire [5:0] take_len_ab = setup_len(chip_select_timing_cfg_i, take_chg);
  wire [5:0] len_c = {4'h0, cfg[ebcs_pkg::CFG_C_POS +: 2]};
  wire [5:0] len_d = {5'h00, cfg[ebcs_pkg::CFG_D_POS]};
  wire [5:0] len_e = {1'b0, cfg[ebcs_pkg::CFG_E_POS +: 5]}
                     + ebcs_pkg::LEN_ONE;
  wire [5:0] len_f = {4'h0, cfg[ebcs_pkg::CFG_F_POS +: 2]};

  // phase after the current one, skipping phases of zero length
  function automatic ebcs_pkg::ebcs_phase_t phase_after(
      input ebcs_pkg::ebcs_phase_t p,
      input logic c_on, input logic d_on, input logic f_on);
    case (p)
      ebcs_pkg::ST_AB: phase_after = c_on ? ebcs_pkg::ST_C :
                       d_on ? ebcs_pkg::ST_D : ebcs_pkg::ST_E;
      ebcs_pkg::ST_C: phase_after = d_on ? ebcs_pkg::ST_D :
                      ebcs_pkg::ST_E;
      ebcs_pkg::ST_D: phase_after = ebcs_pkg::ST_E;
      ebcs_pkg::ST_E: phase_after = f_on ? ebcs_pkg::ST_F :
                      ebcs_pkg::ST_IDLE;
      default: phase_after = ebcs_pkg::ST_IDLE;
    endcase
  endfunction

  // length of a phase, used only for the timer load
  function automatic logic [5:0] phase_len(input ebcs_pkg::ebcs_phase_t p,
      input logic [5:0] lab, input logic [5:0] lc, input logic [5:0] ld,
      input logic [5:0] le, input logic [5:0] lf);
    case (p)
      ebcs_pkg::ST_AB: phase_len = lab;
      ebcs_pkg::ST_C: phase_len = lc;
      ebcs_pkg::ST_D: phase_len = ld;
      ebcs_pkg::ST_E: phase_len = le;
      ebcs_pkg::ST_F: phase_len = lf;
      default: phase_len = 6'h01;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  logic ph_done; // last period of the current phase
  wire [5:0] next_len = (st == ebcs_pkg::ST_IDLE) ? take_len_ab :
    phase_len(next_st, len_ab, len_c, len_d, len_e, len_f);
  wire ph_load = (next_st != st);

  // the setup length comes from the incoming request while idle, as the
  // latched copy lags one edge; idle always lasts at least one period
  always_comb begin
    next_st = st;
    case (st)
      ebcs_pkg::ST_IDLE: begin
        if (take) begin
          next_st = ebcs_pkg::ST_AB;
        end
      end
      ebcs_pkg::ST_AB, ebcs_pkg::ST_C, ebcs_pkg::ST_D, ebcs_pkg::ST_E,
      ebcs_pkg::ST_F: begin
        if (ph_done) begin
          next_st = phase_after(st, len_c != 6'h00, len_d != 6'h00,
                                len_f != 6'h00);
        end
      end
      default: next_st = ebcs_pkg::ST_IDLE;
    endcase
  end

  // timer is loaded on every phase change except into idle, with the new phase length
  ebcs_phase_timer #(.W(ebcs_pkg::LEN_W)) u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(ph_load & (next_st != ebcs_pkg::ST_IDLE)),
    .len_i(next_len),
    .done_o(ph_done)
  );

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ebcs_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // request capture and window tracking
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      we <= 1'b0;
      byte_hi <= 1'b0;
      addr <= '0;
      wdata <= '0;
      cfg <= '0;
      prev_win <= ebcs_pkg::WIN_RST;
      win_seen <= 1'b0;
      win_chg <= 1'b0;
    end else if (take) begin
      we <= req_we_i;
      byte_hi <= req_byte_hi_i;
      addr <= req_addr_i;
      wdata <= req_wdata_i;
      cfg <= chip_select_timing_cfg_i;
      prev_win <= req_window_i;
      win_seen <= 1'b1;
      // the first cycle after reset counts as a window change
      win_chg <= take_chg;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs, registered from the next phase
  // ----------------------------------------------------------------
  logic [ebcs_pkg::DATA_W-1:0] rd_meta; // first sync stage
  logic [ebcs_pkg::DATA_W-1:0] rd_sync; // second sync stage
  wire n_ab = (next_st == ebcs_pkg::ST_AB);
  wire n_e = (next_st == ebcs_pkg::ST_E);
  wire n_act = (next_st != ebcs_pkg::ST_IDLE);
  // on the taking edge the latched copy still holds the last cycle
  wire n_we = take ? req_we_i : we;
  wire n_hi = take ? req_byte_hi_i : byte_hi;
  wire n_mux = take ? chip_select_timing_cfg_i[ebcs_pkg::CFG_MUX_POS] : mux;
  wire [ebcs_pkg::ADDR_W-1:0] n_addr = take ? req_addr_i : addr;
  wire [ebcs_pkg::DATA_W-1:0] n_wd = take ? req_wdata_i : wdata;
  // mux turnaround keeps the shared pins released
  wire n_wdrive = n_we && !n_ab && n_act &&
                  !(n_mux && next_st == ebcs_pkg::ST_D);
  wire n_oe = (n_mux && n_ab) || n_wdrive;
  wire [15:0] n_data = (n_mux && n_ab) ? n_addr[15:0] : n_wd;
  wire rd_end = (st == ebcs_pkg::ST_E) && !n_e && !we;

  // the reference clock is the cpu clock itself, so its period matches
  // one phase unit and every pin changes on its rising edge
  assign bus_reference_clock_out_o = core_clk_i;

  // two stages on the read pins; only the second stage is read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_meta <= '0;
      rd_sync <= '0;
    end else begin
      rd_meta <= data_i;
      rd_sync <= rd_meta;
    end
  end

  // strobes, address and data pins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o <= '0;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      upper_byte_select_n_o <= 1'b1;
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      // address and write data stay put through hold
      addr_o <= n_act ? n_addr : addr_o;
      ale_o <= n_mux && n_ab;
      rd_n_o <= !(n_e && !n_we);
      wr_n_o <= !(n_e && n_we);
      upper_byte_select_n_o <= !(n_act && n_hi);
      data_o <= n_data;
      data_oe_o <= n_oe;
    end
  end

  // read data latched on the edge that raises the read strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
      cycle_done_o <= 1'b0;
    end else begin
      rdata_o <= rd_end ? rd_sync : rdata_o;
      rdata_valid_o <= rd_end;
      cycle_done_o <= n_act == 1'b0 && st != ebcs_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] dwell; // periods spent in the current phase
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dwell <= 6'h01;
    end else begin
      dwell <= ph_load ? 6'h01 : dwell + 6'h01;
    end
  end
  wire leave = ph_load && st != ebcs_pkg::ST_IDLE;

  sequence s_enter_access;
    (st != ebcs_pkg::ST_E) ##1 (st == ebcs_pkg::ST_E);
  endsequence

  a_phase_order: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_AB && leave) |=> (st == ebcs_pkg::ST_C ||
      st == ebcs_pkg::ST_D || st == ebcs_pkg::ST_E))
    else $error("setup phase left to a wrong phase");
  a_setup_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_AB && leave) |-> dwell == len_ab && dwell <= 6'h05)
    else $error("address setup length wrong");
  a_cmd_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_C && leave) |-> dwell == len_c)
    else $error("command delay length wrong");
  a_access_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_E && leave) |-> dwell == len_e)
    else $error("access length wrong");
  a_turn_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_D) |-> dwell == 6'h01 ##1 st != ebcs_pkg::ST_D)
    else $error("turnaround longer than one period");
  a_hold_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_F) |-> $stable(addr_o) && rd_n_o && wr_n_o)
    else $error("address moved or strobe active in hold");
  a_read_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(rd_n_o) |-> rdata_valid_o && rdata_o == $past(rd_sync))
    else $error("read data not latched at strobe rise");
  a_strobe_access: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_enter_access |-> (rd_n_o ^ wr_n_o) throughout
      (st == ebcs_pkg::ST_E) [*1])
    else $error("strobe not active in access");
  a_ale_mux: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ale_o |-> st == ebcs_pkg::ST_AB && mux)
    else $error("latch enable outside mux setup");
  a_hold_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_F && leave) |-> dwell == len_f)
    else $error("hold length wrong");
  a_strobe_span: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st == ebcs_pkg::ST_E) != (rd_n_o && wr_n_o))
    else $error("strobe does not match access phase");

endmodule
`default_nettype wire

// file: design/ebcs_pkg.sv
// package for the external bus cycle sequencer: phase states, timing
// fields and counts shared by the sequencer and its phase timer.
// assumes one cpu clock drives every flip-flop of the block.
package ebcs_pkg;

  // ----------------------------------------------------------------
  // phase states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_AB   = 6'h02,
    ST_C    = 6'h04,
    ST_D    = 6'h08,
    ST_E    = 6'h10,
    ST_F    = 6'h20
  } ebcs_phase_t;

  // ----------------------------------------------------------------
  // chip_select_timing_cfg field layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 14;         // width of the timing word
  localparam int CFG_AB_POS = 0;     // 0: one period, 1: two periods
  localparam int CFG_ABX_POS = 1;    // 2 bits, window change extension
  localparam int CFG_C_POS = 3;      // 2 bits, command delay
  localparam int CFG_D_POS = 5;      // 1 bit, write setup / turnaround
  localparam int CFG_E_POS = 6;      // 5 bits, access length minus one
  localparam int CFG_F_POS = 11;     // 2 bits, hold length
  localparam int CFG_MUX_POS = 13;   // 1: shared_addr_data_mode

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int LEN_W = 6;          // holds up to 63 periods; longest phase is 32
  localparam int ADDR_W = 24;        // external address width
  localparam int DATA_W = 16;        // external data width
  localparam int WIN_W = 3;          // address window index width
  localparam logic [LEN_W-1:0] LEN_ONE = 6'h01;
  localparam logic [WIN_W-1:0] WIN_RST = 3'h0;

  // ----------------------------------------------------------------
  // timing: cpu clock period in ns, counts are in cpu periods
  // ----------------------------------------------------------------
  localparam int CPU_CLK_PERIOD_NS = 100;

endpackage

// file: design/ebcs_phase_timer.sv
// down-counter that times the length of one bus cycle phase.
// assumes load_i is pulsed on the edge that enters a phase.
`timescale 1ns/1ns
`default_nettype none
module ebcs_phase_timer #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] len_i,
  // status
  output logic done_o
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [W-1:0] cnt; // periods left in the phase, counting this one
  logic [W-1:0] next_cnt;

  // done in the last period of the phase, so the fsm leaves on the edge
  assign done_o = (cnt == {{(W-1){1'b0}}, 1'b1});
  assign next_cnt = load_i ? len_i :
                    (cnt > {{(W-1){1'b0}}, 1'b1}) ? cnt - 1'b1 : cnt;

  // counter register; rests at one so an idle timer reads done
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {{(W-1){1'b0}}, 1'b1};
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule
`default_nettype wire

// file: test/ebcs_ext_mem.sv
// far-side model: external memory on the parallel bus, read side only.
// assumes active-low read strobe and an address held while it is low.
`timescale 1ns/1ns
`default_nettype none
module ebcs_ext_mem (
  // bus pins from the sequencer
  input wire logic [ebcs_pkg::ADDR_W-1:0] addr_i,
  input wire logic rd_n_i,
  // read data toward the sequencer
  output logic [ebcs_pkg::DATA_W-1:0] data_o
);
  // ----------------------------------------------------------------
  // read response
  // ----------------------------------------------------------------
  logic [ebcs_pkg::DATA_W-1:0] last; // last word put on the pins
  // one process owns the pins: answer a little late, as a slow part
  // would, and let go after the strobe rises; no pull, so the released
  // pins show the inverse of the last word
  initial begin
    last = 16'h0000;
    data_o = 16'hffff;
    forever begin
      @(negedge rd_n_i);
      #7 last = addr_i[15:0] ^ 16'h5a3c;
      data_o = last;
      @(posedge rd_n_i);
      #3 data_o = ~last;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_ebcs_sequencer.sv
// self-checking bench for the bus cycle sequencer with a memory model.
// assumes the design package is compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_ebcs_sequencer;
  // ----------------------------------------------------------------
  // stimulus and observed pins
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic req_we_i = 1'b0;
  logic req_byte_hi_i = 1'b0;
  logic [ebcs_pkg::WIN_W-1:0] req_window_i = 3'h0;
  logic [ebcs_pkg::ADDR_W-1:0] req_addr_i = 24'h000000;
  logic [ebcs_pkg::DATA_W-1:0] req_wdata_i = 16'h0000;
  logic [ebcs_pkg::CFG_W-1:0] cfg_i = 14'h0000;
  wire logic req_ready_o, rdata_valid_o, cycle_done_o, ref_clk_o;
  wire logic ale_o, rd_n_o, wr_n_o, ubs_n_o, data_oe_o;
  wire logic [ebcs_pkg::DATA_W-1:0] rdata_o, data_i, data_o;
  wire logic [ebcs_pkg::ADDR_W-1:0] addr_o;
  int err_count = 0; // mismatches seen
  int comparisons = 0; // checks made
  logic first_cyc = 1'b1; // next cycle counts as a window change
  logic [2:0] prev_win = 3'h0; // window of the previous request

  always #50 core_clk_i = ~core_clk_i;

  // the reference clock is looked at mid-way through each half period
  always @(posedge core_clk_i) begin
    #25 chk_flag("ref_clk_hi", 1'b1, ref_clk_o);
    #50 chk_flag("ref_clk_lo", 1'b0, ref_clk_o);
  end

  ebcs_sequencer u_ebcs_sequencer (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .req_we_i(req_we_i),
    .req_byte_hi_i(req_byte_hi_i), .req_window_i(req_window_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .chip_select_timing_cfg_i(cfg_i), .rdata_valid_o(rdata_valid_o),
    .rdata_o(rdata_o), .cycle_done_o(cycle_done_o),
    .bus_reference_clock_out_o(ref_clk_o), .addr_o(addr_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .upper_byte_select_n_o(ubs_n_o), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o));
  ebcs_ext_mem u_ebcs_ext_mem (.addr_i(addr_o), .rd_n_i(rd_n_o),
    .data_o(data_i));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk_flag(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0b seen %0b", name, exp, got);
    end
  endtask
  task automatic chk_val(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one bus cycle against the phase model
  // ----------------------------------------------------------------
  task automatic run_cycle(logic we, logic hi, logic [2:0] win,
      logic [23:0] addr, logic [15:0] wd, logic [13:0] cfg);
    int lab, st, e, dn, k, vld_at;
    logic mux;
    mux = cfg[13];
    lab = 1 + cfg[0] + ((first_cyc || win != prev_win) ? cfg[2:1] : 0);
    e = cfg[10:6] + 1;
    st = lab + cfg[4:3] + cfg[5] + 1; // first access cycle
    dn = st + e + cfg[12:11]; // first idle cycle
    first_cyc = 1'b0;
    prev_win = win;
    vld_at = 0;
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_we_i <= we;
    req_byte_hi_i <= hi;
    req_window_i <= win;
    req_addr_i <= addr;
    req_wdata_i <= wd;
    cfg_i <= cfg;
    // ready is looked at where settled, before the taking edge
    @(negedge core_clk_i);
    for (k = 0; k < 20 && req_ready_o !== 1'b1; k++) @(negedge core_clk_i);
    @(posedge core_clk_i);
    req_i <= 1'b0;
    for (k = 1; k <= 60; k++) begin
      @(negedge core_clk_i);
      if (k < dn) begin
        chk_flag("strobe", !(k >= st && k < st + e), we ? wr_n_o : rd_n_o);
        chk_flag("idle_strobe", 1'b1, we ? rd_n_o : wr_n_o);
        chk_flag("ale", mux && k <= lab, ale_o);
        chk_flag("ubs_n", !hi, ubs_n_o);
        chk_flag("busy", 1'b0, req_ready_o);
      end
      chk_val("addr", addr, addr_o);
      if (we && k >= st && k < dn) begin
        chk_val("wdata", wd, data_o);
        chk_flag("wdata_oe", 1'b1, data_oe_o);
      end
      if (we && mux && k > st - 1 - cfg[5] && k < st)
        chk_flag("turnaround_oe", 1'b0, data_oe_o);
      if (mux && k <= lab) begin
        chk_val("mux_addr", addr[15:0], data_o);
        chk_flag("mux_addr_oe", 1'b1, data_oe_o);
      end
      if (!we && k > lab && k < dn)
        chk_flag("read_oe", 1'b0, data_oe_o);
      if (rdata_valid_o === 1'b1) vld_at = k;
      if (cycle_done_o === 1'b1) break;
    end
    chk_val("done_at", dn, k);
    chk_flag("ready", 1'b1, req_ready_o);
    chk_val("valid_at", we ? 0 : st + e, vld_at);
    if (!we) chk_val("rdata", addr[15:0] ^ 16'h5a3c, rdata_o);
  endtask

  // sweep command delay, turnaround, hold, mode and direction
  task automatic run_batch(int n);
    logic [4:0] ef;
    logic [2:0] win;
    for (int i = 0; i < n; i++) begin
      // the partner answers late, so reads get three or more periods
      ef = i[1] ? (i[2] ? 5'h1f : 5'h00) : 5'($urandom_range(31, 2));
      win = $urandom_range(1, 0) ? prev_win : 3'($urandom);
      run_cycle(i[1], 1'($urandom), win, 24'($urandom), 16'($urandom),
        {i[0], i[6:5], ef, i[2], i[4:3], 2'($urandom), 1'($urandom)});
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h460d));
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    run_batch(128);
    // a reset in the middle of a long access must park the pins
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_we_i <= 1'b0;
    cfg_i <= 14'h07c0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b1;
    req_i <= 1'b0;
    @(negedge core_clk_i);
    chk_flag("rst_rd_n", 1'b1, rd_n_o);
    chk_flag("rst_ready", 1'b1, req_ready_o);
    chk_flag("rst_ale", 1'b0, ale_o);
    chk_flag("rst_oe", 1'b0, data_oe_o);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    first_cyc = 1'b1;
    run_batch(8);
    summarize();
  end

  initial begin
    #(20000 * 100);
    err_count++;
    $display("mismatch watchdog expected finish seen timeout");
    summarize();
  end
endmodule
`default_nettype wire
